// File: sswd_core.sv
`timescale 1ns/1ns
`include "sswd_params.svh"
// What this block does
// - Watchdog tick lasts divider plus two base periods, each one 50 ns clock.
// - One divider register prescales both watchdogs.
// - Each watchdog has its own count times the shared tick.
// - Reset values: divider 2498, bus-side count 1000.
// - Bus watchdog expiry with outputs set clears outputs.
// - Count zero disables bus watchdog; outputs stay on link loss.
// - Counts 0..65535, divider 1..65535 accepted.
// - Power-on enters Init; mailbox and process data refused.
// - Init to Pre-Op requires valid mailbox configuration.
// - Pre-Op allows mailbox only; master sets process data setup.
// - Pre-Op to Safe-Op checks setup, copies inputs on the acknowledge edge.
// - Safe-Op allows both traffic kinds, updates inputs, outputs safe.
// - With watchdog off, outputs follow commands in Safe-Op.
// - Op copies master outputs to physical outputs.
// - Boot only from Init; other Boot requests rejected.
// - Boot allows only firmware-file mailbox traffic.
// - Bus process data access restarts bus watchdog.
// - Bus expiry forces outputs false, state unchanged.
// - Local watchdog fires without local access within timeout.
module sswd_core
#(
    parameter int OUT_W = 8,
    parameter int IN_W  = 8
)
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // Register port
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [11:0]      reg_addr,
    input  wire logic [15:0]      reg_wdata,
    output logic      [15:0]      reg_rdata_r,
    // Bus side events
    input  wire logic             pd_access,
    input  wire logic             state_req,
    input  wire logic [2:0]       state_req_code,
    input  wire logic             mbx_cfg_ok,
    input  wire logic             pd_cfg_ok,
    input  wire logic             dc_cfg_ok,
    input  wire logic [OUT_W-1:0] out_cmd,
    // Local side
    input  wire logic             local_access,
    input  wire logic [IN_W-1:0]  phys_in,
    input  wire logic             mbx_is_file,
    // Results
    output logic [OUT_W-1:0]      phys_out_r,
    output logic [IN_W-1:0]       dpram_in_r,
    output logic [2:0]            state_r,
    output logic                  req_ack_r,
    output logic                  req_err_r,
    output logic                  mbx_allow_r,
    output logic                  pd_allow_r,
    output logic                  bus_wd_exp_r,
    output logic                  local_wd_exp_r
);
    sswd_pkg::sswd_state_t st_r;
    sswd_pkg::sswd_state_t st_nxt;
    logic [15:0] tick_div_r;
    logic [15:0] local_wd_r;
    logic [15:0] bus_wd_r;
    logic [16:0] pre_r;
    logic        tick_r;
    logic        bus_exp;
    logic        local_exp;
    logic        req_ok;

    // Registers keep their values unless software writes them
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_div_r <= `SSWD_RST_TICK_DIV;
            local_wd_r <= `SSWD_RST_LOCAL_WD;
            bus_wd_r   <= `SSWD_RST_BUS_WD;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `SSWD_OFS_TICK_DIV:
                    // Zero is outside the range; hold the old value
                    if (reg_wdata != 16'h0000)
                        tick_div_r <= reg_wdata;
                `SSWD_OFS_LOCAL_WD: local_wd_r <= reg_wdata;
                `SSWD_OFS_BUS_WD:   bus_wd_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata_r <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `SSWD_OFS_TICK_DIV: reg_rdata_r <= tick_div_r;
                `SSWD_OFS_LOCAL_WD: reg_rdata_r <= local_wd_r;
                `SSWD_OFS_BUS_WD:   reg_rdata_r <= bus_wd_r;
                default:            reg_rdata_r <= 16'h0000;
            endcase
        end
    end

    // Shared prescaler; local clock is slower than the base period,
    // so each base period costs at least one whole cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_r  <= 17'h00000;
            tick_r <= 1'b0;
        end
        else if (pre_r + 17'h00001 >= 17'((tick_div_r + 17'd`SSWD_TICK_EXTRA)
                                         * `SSWD_BASE_CYC))
        begin
            pre_r  <= 17'h00000;
            tick_r <= 1'b1;
        end
        else
        begin
            pre_r  <= pre_r + 17'h00001;
            tick_r <= 1'b0;
        end
    end

    sswd_timeout #(.W(16)) u_bus_wd
    (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .tick      (tick_r),
        .kick      (pd_access),
        .limit     (bus_wd_r),
        .expired_r (bus_exp)
    );

    sswd_timeout #(.W(16)) u_local_wd
    (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .tick      (tick_r),
        .kick      (local_access),
        .limit     (local_wd_r),
        .expired_r (local_exp)
    );

    // Transition decision
    always_comb
    begin
        st_nxt = st_r;
        req_ok = 1'b0;
        if (state_req)
        begin
            case (state_req_code)
                `SSWD_REQ_INIT:
                begin
                    st_nxt = sswd_pkg::SSWD_INIT;
                    req_ok = 1'b1;
                end
                `SSWD_REQ_PREOP:
                    if ((st_r == sswd_pkg::SSWD_INIT && mbx_cfg_ok)
                        || st_r == sswd_pkg::SSWD_SAFEOP
                        || st_r == sswd_pkg::SSWD_OP)
                    begin
                        st_nxt = sswd_pkg::SSWD_PREOP;
                        req_ok = 1'b1;
                    end
                `SSWD_REQ_SAFEOP:
                    if ((st_r == sswd_pkg::SSWD_PREOP
                         && pd_cfg_ok && dc_cfg_ok)
                        || st_r == sswd_pkg::SSWD_OP)
                    begin
                        st_nxt = sswd_pkg::SSWD_SAFEOP;
                        req_ok = 1'b1;
                    end
                `SSWD_REQ_OP:
                    if (st_r == sswd_pkg::SSWD_SAFEOP)
                    begin
                        st_nxt = sswd_pkg::SSWD_OP;
                        req_ok = 1'b1;
                    end
                `SSWD_REQ_BOOT:
                    if (st_r == sswd_pkg::SSWD_INIT)
                    begin
                        st_nxt = sswd_pkg::SSWD_BOOT;
                        req_ok = 1'b1;
                    end
                default: ;
            endcase
        end
    end

    // Bus expiry never changes state, only the outputs
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= sswd_pkg::SSWD_INIT;
        else
            st_r <= st_nxt;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_ack_r <= 1'b0;
            req_err_r <= 1'b0;
        end
        else
        begin
            req_ack_r <= state_req && req_ok;
            req_err_r <= state_req && !req_ok;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            state_r <= 3'h0;
        else
            state_r <= 3'(st_nxt);
    end

    // Inputs sampled in the same edge as the Safe-Op acknowledge
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            dpram_in_r <= '0;
        else if (st_nxt == sswd_pkg::SSWD_SAFEOP
                 || st_nxt == sswd_pkg::SSWD_OP)
            dpram_in_r <= phys_in;
    end

    // Traffic gating follows the state being entered
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mbx_allow_r <= 1'b0;
            pd_allow_r  <= 1'b0;
        end
        else
        begin
            case (st_nxt)
                sswd_pkg::SSWD_INIT:
                begin
                    mbx_allow_r <= 1'b0;
                    pd_allow_r  <= 1'b0;
                end
                sswd_pkg::SSWD_PREOP:
                begin
                    mbx_allow_r <= 1'b1;
                    pd_allow_r  <= 1'b0;
                end
                sswd_pkg::SSWD_BOOT:
                begin
                    mbx_allow_r <= mbx_is_file;
                    pd_allow_r  <= 1'b0;
                end
                sswd_pkg::SSWD_SAFEOP, sswd_pkg::SSWD_OP:
                begin
                    mbx_allow_r <= 1'b1;
                    pd_allow_r  <= 1'b1;
                end
                default:
                begin
                    mbx_allow_r <= 1'b0;
                    pd_allow_r  <= 1'b0;
                end
            endcase
        end
    end

    // Outputs: safe unless Op, or Safe-Op with bus watchdog off
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            phys_out_r <= '0;
        else if (bus_exp)
            phys_out_r <= '0;
        else if (st_nxt == sswd_pkg::SSWD_OP)
            phys_out_r <= out_cmd;
        else if (st_nxt == sswd_pkg::SSWD_SAFEOP && bus_wd_r == 16'h0000)
            phys_out_r <= out_cmd;
        else
            phys_out_r <= '0;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_wd_exp_r   <= 1'b0;
            local_wd_exp_r <= 1'b0;
        end
        else
        begin
            bus_wd_exp_r   <= bus_exp;
            local_wd_exp_r <= local_exp;
        end
    end
endmodule

// File: sswd_params.svh
`ifndef SSWD_PARAMS_SVH
`define SSWD_PARAMS_SVH

// Register offsets
`define SSWD_OFS_TICK_DIV     12'h400
`define SSWD_OFS_LOCAL_WD     12'h410
`define SSWD_OFS_BUS_WD       12'h420

// Reset values
`define SSWD_RST_TICK_DIV     16'h09C2
`define SSWD_RST_LOCAL_WD     16'h03E8
`define SSWD_RST_BUS_WD       16'h03E8

// Tick length is divider plus this many base cycles
`define SSWD_TICK_EXTRA       2

// Base period and clock figures
`define SSWD_BASE_NS          40
`define SSWD_CLK_NS           50
// Local clock cycles per base period: ceil(40/50) keeps at least one cycle
`define SSWD_BASE_CYC ((`SSWD_BASE_NS + `SSWD_CLK_NS - 1) / `SSWD_CLK_NS)

// State request codes
`define SSWD_REQ_INIT         3'h1
`define SSWD_REQ_PREOP        3'h2
`define SSWD_REQ_BOOT         3'h3
`define SSWD_REQ_SAFEOP       3'h4
`define SSWD_REQ_OP           3'h6

`endif

// File: sswd_pkg.sv
package sswd_pkg;
    typedef enum logic [2:0]
    {
        SSWD_INIT,
        SSWD_PREOP,
        SSWD_SAFEOP,
        SSWD_OP,
        SSWD_BOOT
    } sswd_state_t;
endpackage

// File: sswd_timeout.sv
`timescale 1ns/1ns
module sswd_timeout
#(
    parameter int W = 16
)
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_b,
    // Control
    input  wire logic         tick,
    input  wire logic         kick,
    input  wire logic [W-1:0] limit,
    // Status
    output logic              expired_r
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_r     <= '0;
            expired_r <= 1'b0;
        end
        else if (kick || limit == '0)
        begin
            // Zero limit switches the watchdog off entirely
            cnt_r     <= '0;
            expired_r <= 1'b0;
        end
        else if (tick && !expired_r)
        begin
            if (cnt_r + W'(1) >= limit)
                expired_r <= 1'b1;
            cnt_r <= cnt_r + W'(1);
        end
    end
endmodule

// File: sswd_core_monitor.sv
`timescale 1ns/1ns
module sswd_core_monitor
#(
    parameter int OUT_W = 8
)
(
    // Clock and reset
    input wire logic             mclk,
    input wire logic             rst_b,
    // Requests and data
    input wire logic             state_req,
    input wire logic [2:0]       state_req_code,
    input wire logic [OUT_W-1:0] out_cmd,
    input wire logic             pd_access,
    // Results
    input wire logic [OUT_W-1:0] phys_out_r,
    input wire logic [2:0]       state_r,
    input wire logic             req_ack_r,
    input wire logic             req_err_r,
    input wire logic             mbx_allow_r,
    input wire logic             pd_allow_r,
    input wire logic             bus_wd_exp_r
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    property p_init;
        state_r == 3'h0 |-> !mbx_allow_r && !pd_allow_r;
    endproperty
    a_init: assert property (p_init) else $error("init open");
    property p_preop;
        state_r == 3'h1 |-> mbx_allow_r && !pd_allow_r;
    endproperty
    a_preop: assert property (p_preop) else $error("preop gate");
    property p_boot;
        state_req && state_req_code == 3'h3 && state_r != 3'h0
            |=> req_err_r && $stable(state_r);
    endproperty
    a_boot: assert property (p_boot) else $error("boot taken");
    property p_quiet;
        !state_req |=> !req_ack_r && !req_err_r;
    endproperty
    a_quiet: assert property (p_quiet) else $error("unasked");
    // Two Op samples so the expiry lag never overlaps
    property p_copy;
        state_r == 3'h3 && !bus_wd_exp_r ##1 state_r == 3'h3 && !bus_wd_exp_r
            |-> phys_out_r == $past(out_cmd);
    endproperty
    a_copy: assert property (p_copy) else $error("op copy");
    property p_clear;
        bus_wd_exp_r |-> phys_out_r == {OUT_W{1'b0}};
    endproperty
    a_clear: assert property (p_clear) else $error("outputs kept");
    property p_hold;
        $rose(bus_wd_exp_r) && !$past(state_req) |-> $stable(state_r);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved");
    // Flag lags the internal clear by one cycle
    property p_kick;
        pd_access |-> ##2 !bus_wd_exp_r;
    endproperty
    a_kick: assert property (p_kick) else $error("kick lost");
endmodule

bind sswd_core sswd_core_monitor #(.OUT_W(OUT_W)) u_mon (.*);

// File: sswd_master_model.sv
`timescale 1ns/1ns
module sswd_master_model
(
    // Clock
    input wire logic    mclk,
    // Register port
    output logic        reg_wr,
    output logic        reg_rd,
    output logic [11:0] reg_addr,
    output logic [15:0] reg_wdata,
    // State requests and setup results
    output logic        state_req,
    output logic [2:0]  state_req_code,
    output logic        mbx_cfg_ok,
    output logic        pd_cfg_ok,
    output logic        dc_cfg_ok,
    // Process data
    output logic        pd_access,
    output logic [7:0]  out_cmd
);
    initial
        {reg_wr, reg_rd, reg_addr, reg_wdata, state_req, state_req_code,
         mbx_cfg_ok, pd_cfg_ok, dc_cfg_ok, pd_access, out_cmd} = 46'h0;
    // Released lines show the inverse, never a stale copy
    task bus(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(negedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(negedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
        @(negedge mclk);
    endtask
    task req(input logic [2:0] c, input logic [2:0] ok, input logic [7:0] v);
        out_cmd = v;
        @(negedge mclk);
        {mbx_cfg_ok, pd_cfg_ok, dc_cfg_ok} = ok;
        {state_req, state_req_code} = {1'b1, c};
        @(negedge mclk);
        state_req = 1'b0;
    endtask
    task kick;
        @(negedge mclk);
        pd_access = 1'b1;
        @(negedge mclk);
        pd_access = 1'b0;
    endtask
endmodule

// File: sswd_core_test.sv
`timescale 1ns/1ns
module sswd_core_test;
    logic        mclk = 1'b0;
    logic        rst_b, reg_wr, reg_rd, state_req, mbx_cfg_ok, pd_cfg_ok;
    logic        dc_cfg_ok, pd_access, local_access, mbx_is_file, req_ack_r;
    logic        req_err_r, mbx_allow_r, pd_allow_r, bus_wd_exp_r;
    logic        local_wd_exp_r;
    logic [2:0]  state_req_code, state_r;
    logic [7:0]  out_cmd, phys_in, phys_out_r, dpram_in_r;
    logic [11:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata_r;
    int          errors = 0;
    int          samples_checked = 0;
    int          n;
    // Nibbles: code, setup flags, refused, resulting state
    logic [15:0] rows [17] = '{16'h4710, 16'h2310, 16'h2701, 16'h3711,
        16'h4511, 16'h4611, 16'h4702, 16'h3712, 16'h6703, 16'h3713,
        16'h4702, 16'h6703, 16'h2701, 16'h1700, 16'h3704, 16'h2714,
        16'h1700};

    always #25 mclk = ~mclk;

    sswd_master_model M (.*);
    sswd_core DUT (.*);

    task chk(input string s, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task close_out;
        $display("errors %0d checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Tick phase runs free, so up to one tick early is legal
    task wd_time(input logic bus, input int t, p);
        n = 0;
        while ((bus ? bus_wd_exp_r : local_wd_exp_r) !== 1'b1 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        chk("wd_time", 16'h1, 16'(n > t - p && n <= t + 4));
        if (n >= 400)
            close_out();
    endtask

    initial
    begin
        {rst_b, local_access, mbx_is_file} = 3'h0;
        phys_in = 8'h3C;
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            M.bus(1'b0, 12'h400 + 12'(i * 16), 16'h0);
            chk("reg_rst", i ? 16'h3E8 : 16'h9C2, reg_rdata_r);
        end
        M.bus(1'b1, 12'h400, 16'h0);
        M.bus(1'b0, 12'h400, 16'h0);
        chk("div_zero", 16'h9C2, reg_rdata_r);
        M.bus(1'b0, 12'h404, 16'h0);
        chk("unmapped", 16'h0, reg_rdata_r);
        $display("registers done");
        foreach (rows[i])
        begin
            M.req(rows[i][14:12], rows[i][10:8], 8'h0);
            chk("req", 16'({!rows[i][4], rows[i][4], rows[i][2:0]}),
                16'({req_ack_r, req_err_r, state_r}));
        end
        mbx_is_file = 1'b1;
        M.req(3'h3, 3'h7, 8'h0);
        @(negedge mclk);
        chk("boot_gate", 16'h2, 16'({mbx_allow_r, pd_allow_r}));
        mbx_is_file = 1'b0;
        @(negedge mclk);
        chk("boot_gate", 16'h0, 16'({mbx_allow_r, pd_allow_r}));
        M.req(3'h1, 3'h7, 8'h0);
        $display("transitions done");
        M.req(3'h2, 3'h7, 8'h0);
        M.req(3'h4, 3'h7, 8'h5A);
        @(negedge mclk);
        chk("dpram", 16'h3C, 16'(dpram_in_r));
        chk("safe_gate", 16'h3, 16'({mbx_allow_r, pd_allow_r}));
        chk("safe_out", 16'h0, 16'(phys_out_r));
        M.req(3'h6, 3'h7, 8'hA5);
        @(negedge mclk);
        chk("op_out", 16'hA5, 16'(phys_out_r));
        M.bus(1'b1, 12'h400, 16'h1);
        M.bus(1'b1, 12'h420, 16'h3);
        M.kick();
        wd_time(1'b1, 9, 3);
        chk("exp_out", 16'h0, 16'(phys_out_r));
        chk("exp_state", 16'h3, 16'(state_r));
        M.kick();
        @(negedge mclk);
        chk("kicked", 16'h0, 16'(bus_wd_exp_r));
        M.bus(1'b1, 12'h400, 16'h4);
        M.bus(1'b1, 12'h410, 16'h2);
        M.bus(1'b0, 12'h410, 16'h0);
        chk("wd_rd", 16'h2, reg_rdata_r);
        local_access = 1'b1;
        @(negedge mclk);
        local_access = 1'b0;
        // Let an expiry from before the kick drain out of the flag
        @(negedge mclk);
        wd_time(1'b0, 12, 6);
        M.bus(1'b1, 12'h420, 16'h0);
        M.req(3'h4, 3'h7, 8'hA5);
        repeat (40) @(negedge mclk);
        chk("wd_off", 16'h0, 16'(bus_wd_exp_r));
        chk("safe_cmd", 16'hA5, 16'(phys_out_r));
        $display("watchdogs done");
        rst_b = 1'b0;
        @(negedge mclk);
        rst_b = 1'b1;
        M.bus(1'b0, 12'h420, 16'h0);
        chk("rst_wd", 16'h3E8, reg_rdata_r);
        chk("rst_state", 16'h0, 16'(state_r));
        $display("reset done");
        close_out();
    end
endmodule
